/* rtl/bsr_defines.svh */
// constants for the boundary-scan test logic
`ifndef BSR_DEFINES_SVH
`define BSR_DEFINES_SVH

`define BSR_IR_W          3
`define BSR_IR_CAPTURE    3'h1
`define BSR_OP_EXTEST     3'h0
`define BSR_OP_IDCODE     3'h1
`define BSR_OP_SAMPLE     3'h2
`define BSR_OP_CLAMP      3'h3
`define BSR_OP_HIGHZ      3'h4
`define BSR_OP_BYPASS     3'h7
`define BSR_ID_W          32
`define BSR_CELLS         245
`define BSR_TX_EN_CELL    161
`define BSR_TX0_CELL      162
`define BSR_BUS_EN_CELL   210
`define BSR_BUS_OUT_CELL  196
`define BSR_BUS_OBS_CELL  197

`endif

/* rtl/bsr_pkg.sv */
// types for the boundary-scan test logic
package bsr_pkg;

  typedef enum logic [3:0] {
    BSR_TLR  = 4'h0,
    BSR_RTI  = 4'h1,
    BSR_SDR  = 4'h2,
    BSR_CDR  = 4'h3,
    BSR_SHDR = 4'h4,
    BSR_E1DR = 4'h5,
    BSR_PDR  = 4'h6,
    BSR_E2DR = 4'h7,
    BSR_UDR  = 4'h8,
    BSR_SIR  = 4'h9,
    BSR_CIR  = 4'ha,
    BSR_SHIR = 4'hb,
    BSR_E1IR = 4'hc,
    BSR_PIR  = 4'hd,
    BSR_E2IR = 4'he,
    BSR_UIR  = 4'hf
  } bsr_tap_t;

  typedef struct packed {
    logic [1:0]   rst_sync;
    logic [2:0]   tck_sync;
    logic [1:0]   tms_sync;
    logic [1:0]   tdi_sync;
    bsr_tap_t     tap;
    logic [2:0]   ir_shift;
    logic [2:0]   ir_cur;
    logic         byp;
    logic [31:0]  id_shift;
    logic [31:0]  id_par;
    logic [244:0] bs_shift;
    logic [244:0] bs_par;
    logic         tdo;
    logic         tdo_en;
    logic [7:0]   bus_out;
    logic [7:0]   bus_oe;
    logic         tx0_out;
    logic         tx0_oe;
    logic         test_mode;
  } bsr_state_t;

endpackage : bsr_pkg

/* rtl/bsr_tap.sv */
// boundary-scan tap, instruction, bypass, identification and boundary registers
`timescale 1ns/10ps
`default_nettype none
`include "bsr_defines.svh"

//////////////////////////////////////////////////////////////////////////////
module bsr_tap
  import bsr_pkg::*;
#(
  parameter logic [10:0] MAKER_ID   = 11'h055, // arbitrary value
  parameter logic [15:0] DEVICE_ID  = 16'h1234, // arbitrary value
  parameter logic [3:0]  VERSION_ID = 4'h0      // arbitrary value
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_resetn,
  // test port pins
  input  wire logic         i_test_clock_pin,
  input  wire logic         i_test_mode_select_pin,
  input  wire logic         i_test_serial_in_pin,
  input  wire logic         i_test_reset_n_pin,
  output logic              o_test_serial_out_pin,
  output logic              o_test_serial_out_oe,
  // pin values seen by the cells
  input  wire logic [244:0] i_pin_sample,
  // functional values for two controlled pin groups
  input  wire logic         i_port0_tx_serial_out,
  input  wire logic [7:0]   i_cpu_bus_out,
  input  wire logic         i_cpu_bus_oe,
  // pin drive
  output logic              o_port0_tx_serial_out,
  output logic              o_port0_tx_serial_oe,
  output logic [7:0]        o_cpu_bus_out,
  output logic [7:0]        o_cpu_bus_oe,
  output logic              o_test_mode
);

  bsr_state_t s_reg;
  bsr_state_t s_next;

  function automatic logic sel_bypass(input logic [2:0] op);
    sel_bypass = !(op == `BSR_OP_EXTEST || op == `BSR_OP_SAMPLE || op == `BSR_OP_IDCODE);
  endfunction : sel_bypass

  logic       rise;
  logic       fall;
  logic       tms;
  logic       tdi;
  logic       trst_n;
  logic [31:0] id_value;
  logic        ext;
  logic        drive;

  assign rise     = s_reg.tck_sync[1] & ~s_reg.tck_sync[2];
  assign fall     = ~s_reg.tck_sync[1] & s_reg.tck_sync[2];
  assign tms      = s_reg.tms_sync[1];
  assign tdi      = s_reg.tdi_sync[1];
  assign trst_n   = s_reg.rst_sync[1];
  assign id_value = {VERSION_ID, DEVICE_ID, MAKER_ID, 1'b1};

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next          = s_reg;
    s_next.rst_sync = {s_reg.rst_sync[0], i_test_reset_n_pin};
    s_next.tck_sync = {s_reg.tck_sync[1:0], i_test_clock_pin};
    s_next.tms_sync = {s_reg.tms_sync[0], i_test_mode_select_pin};
    s_next.tdi_sync = {s_reg.tdi_sync[0], i_test_serial_in_pin};
    ext   = 1'b0;
    drive = 1'b0;
    if (!trst_n) begin
      s_next.tap    = BSR_TLR;
      s_next.ir_cur = `BSR_OP_IDCODE;
    end else if (rise) begin
      case (s_reg.tap)
        BSR_TLR:  s_next.tap = tms ? BSR_TLR  : BSR_RTI;
        BSR_RTI:  s_next.tap = tms ? BSR_SDR  : BSR_RTI;
        BSR_SDR:  s_next.tap = tms ? BSR_SIR  : BSR_CDR;
        BSR_CDR:  s_next.tap = tms ? BSR_E1DR : BSR_SHDR;
        BSR_SHDR: s_next.tap = tms ? BSR_E1DR : BSR_SHDR;
        BSR_E1DR: s_next.tap = tms ? BSR_UDR  : BSR_PDR;
        BSR_PDR:  s_next.tap = tms ? BSR_E2DR : BSR_PDR;
        BSR_E2DR: s_next.tap = tms ? BSR_UDR  : BSR_SHDR;
        BSR_UDR:  s_next.tap = tms ? BSR_SDR  : BSR_RTI;
        BSR_SIR:  s_next.tap = tms ? BSR_TLR  : BSR_CIR;
        BSR_CIR:  s_next.tap = tms ? BSR_E1IR : BSR_SHIR;
        BSR_SHIR: s_next.tap = tms ? BSR_E1IR : BSR_SHIR;
        BSR_E1IR: s_next.tap = tms ? BSR_UIR  : BSR_PIR;
        BSR_PIR:  s_next.tap = tms ? BSR_E2IR : BSR_PIR;
        BSR_E2IR: s_next.tap = tms ? BSR_UIR  : BSR_SHIR;
        BSR_UIR:  s_next.tap = tms ? BSR_SDR  : BSR_RTI;
        default:  s_next.tap = BSR_TLR;
      endcase
      case (s_reg.tap)
        BSR_CIR:  s_next.ir_shift = `BSR_IR_CAPTURE;
        BSR_SHIR: s_next.ir_shift = {tdi, s_reg.ir_shift[2:1]};
        BSR_CDR: begin
          if (s_reg.ir_cur == `BSR_OP_IDCODE) begin
            s_next.id_shift = id_value;
          end else if (s_reg.ir_cur == `BSR_OP_EXTEST || s_reg.ir_cur == `BSR_OP_SAMPLE) begin
            s_next.bs_shift = i_pin_sample;
          end else begin
            s_next.byp = 1'b0;
          end
        end
        BSR_SHDR: begin
          if (s_reg.ir_cur == `BSR_OP_IDCODE) begin
            s_next.id_shift = {tdi, s_reg.id_shift[31:1]};
          end else if (sel_bypass(s_reg.ir_cur)) begin
            s_next.byp = tdi;
          end else begin
            s_next.bs_shift = {tdi, s_reg.bs_shift[244:1]};
          end
        end
        default: begin
        end
      endcase
    end else if (fall) begin
      if (s_reg.tap == BSR_UIR) begin
        s_next.ir_cur = s_reg.ir_shift;
      end else if (s_reg.tap == BSR_UDR) begin
        if (s_reg.ir_cur == `BSR_OP_IDCODE) begin
          s_next.id_par = s_reg.id_shift;
        end else if (!sel_bypass(s_reg.ir_cur)) begin
          s_next.bs_par = s_reg.bs_shift;
        end
      end else if (s_reg.tap == BSR_TLR) begin
        s_next.ir_cur = `BSR_OP_IDCODE;
      end
      s_next.tdo_en = (s_reg.tap == BSR_SHIR) || (s_reg.tap == BSR_SHDR);
      if (s_reg.tap == BSR_SHIR) begin
        s_next.tdo = s_reg.ir_shift[0];
      end else if (s_reg.ir_cur == `BSR_OP_IDCODE) begin
        s_next.tdo = s_reg.id_shift[0];
      end else if (sel_bypass(s_reg.ir_cur)) begin
        s_next.tdo = s_reg.byp;
      end else begin
        s_next.tdo = s_reg.bs_shift[0];
      end
    end
    // output cells take over under extest and clamp; highz floats all
    ext = (s_reg.ir_cur == `BSR_OP_EXTEST) || (s_reg.ir_cur == `BSR_OP_CLAMP);
    s_next.test_mode = ext || (s_reg.ir_cur == `BSR_OP_HIGHZ);
    if (s_reg.ir_cur == `BSR_OP_HIGHZ) begin
      s_next.tx0_oe = 1'b0;
      s_next.bus_oe = 8'h00;
    end else if (ext) begin
      s_next.tx0_out = s_reg.bs_par[`BSR_TX0_CELL];
      s_next.tx0_oe  = s_reg.bs_par[`BSR_TX_EN_CELL];
      drive          = s_reg.bs_par[`BSR_BUS_EN_CELL];
      for (int k = 0; k < 8; k++) begin
        s_next.bus_out[k] = s_reg.bs_par[`BSR_BUS_OUT_CELL + 2 * k];
        s_next.bus_oe[k]  = drive;
      end
    end else begin
      s_next.tx0_out = i_port0_tx_serial_out;
      s_next.tx0_oe  = 1'b1;
      s_next.bus_out = i_cpu_bus_out;
      s_next.bus_oe  = {8{i_cpu_bus_oe}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_reg        <= '0;
      s_reg.tap    <= BSR_TLR;
      s_reg.ir_cur <= `BSR_OP_IDCODE;
      s_reg.id_par <= 32'h00000001;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_test_serial_out_pin = s_reg.tdo;
  assign o_test_serial_out_oe  = s_reg.tdo_en;
  assign o_port0_tx_serial_out = s_reg.tx0_out;
  assign o_port0_tx_serial_oe  = s_reg.tx0_oe;
  assign o_cpu_bus_out         = s_reg.bus_out;
  assign o_cpu_bus_oe          = s_reg.bus_oe;
  assign o_test_mode           = s_reg.test_mode;

endmodule : bsr_tap
`default_nettype wire

/* sim/bsr_tap_props.sv */
// port assertions for the boundary-scan test logic
`timescale 1ns/10ps
`default_nettype none
module bsr_tap_props (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_resetn,
  // test port
  input wire logic       i_test_clock_pin,
  input wire logic       i_test_reset_n_pin,
  input wire logic       o_test_serial_out_pin,
  input wire logic       o_test_serial_out_oe,
  // bus and pin drive
  input wire logic [7:0] i_cpu_bus_out,
  input wire logic       i_cpu_bus_oe,
  input wire logic [7:0] o_cpu_bus_out,
  input wire logic [7:0] o_cpu_bus_oe,
  input wire logic       o_test_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  sequence fn;
    !o_test_mode && $past(i_resetn, 3);
  endsequence
  // test outputs move only a few cycles after the test clock fell
  sequence tck_fell;
    !$past(i_test_clock_pin, 2) && $past(i_test_clock_pin, 7);
  endsequence
  func_bus_a: assert property (fn |-> o_cpu_bus_out == $past(i_cpu_bus_out))
    else $error("bus data not passed");
  func_oe_a: assert property (fn |-> o_cpu_bus_oe == {8{$past(i_cpu_bus_oe)}})
    else $error("bus enable not passed");
  tdo_fall_a: assert property ($changed(o_test_serial_out_pin) |-> tck_fell)
    else $error("serial out moved early");
  tdo_oe_a: assert property ($changed(o_test_serial_out_oe) |-> tck_fell)
    else $error("serial enable moved early");
  mode_on_a: assert property ($rose(o_test_mode) |-> tck_fell)
    else $error("instruction latched early");
  hold_out_a: assert property (o_test_mode && $past(o_test_mode) &&
    $changed({o_cpu_bus_out, o_cpu_bus_oe}) |-> tck_fell) else $error("pins moved early");
  trst_a: assert property ($fell(i_test_reset_n_pin) |-> ##[1:8] !o_test_mode)
    else $error("test reset ignored");
  bus_oe_a: assert property (o_test_mode |-> o_cpu_bus_oe inside {8'h00, 8'hff})
    else $error("bus enables split");
  c_mode: cover property ($rose(o_test_mode));
  c_shift: cover property ($rose(o_test_serial_out_oe));
  c_trst: cover property ($fell(i_test_reset_n_pin) ##8 !o_test_mode);
endmodule : bsr_tap_props
bind bsr_tap bsr_tap_props bsr_tap_props_i (.i_mclk(i_mclk), .i_resetn(i_resetn),
  .i_test_clock_pin(i_test_clock_pin), .i_test_reset_n_pin(i_test_reset_n_pin),
  .o_test_serial_out_pin(o_test_serial_out_pin), .o_test_serial_out_oe(o_test_serial_out_oe),
  .i_cpu_bus_out(i_cpu_bus_out), .i_cpu_bus_oe(i_cpu_bus_oe), .o_cpu_bus_out(o_cpu_bus_out),
  .o_cpu_bus_oe(o_cpu_bus_oe), .o_test_mode(o_test_mode));
`default_nettype wire

/* sim/bsr_tester.sv */
// external tester driving the serial test port
`timescale 1ns/10ps
`default_nettype none
module bsr_tester (
  // clock
  input  wire logic i_mclk,
  // test port
  input  wire logic i_tdo,
  output var logic  o_tck,
  output var logic  o_tms,
  output var logic  o_tdi
);
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // one 200 ns test clock period, clock parked low between calls
  task automatic step(input logic ms, input logic di, output logic got);
    @(posedge i_mclk);
    o_tms <= ms;
    o_tdi <= di;
    repeat (3) @(posedge i_mclk);
    o_tck <= 1'b1;
    repeat (4) @(posedge i_mclk);
    got = i_tdo;
    o_tck <= 1'b0;
  endtask : step
endmodule : bsr_tester
`default_nettype wire

/* sim/test_bsr_tap.sv */
// self-checking bench for the boundary-scan test logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: %h %h", $time, g, e); end end
module test_bsr_tap;
  logic         clk = 1'b0, rst_n = 1'b0, trst_n = 1'b1, tx_i = 1'b1, oe_i = 1'b1;
  logic         tck, tms, tdi, tdo, tdo_oe, tx_o, tx_oe, mode, b;
  logic [7:0]   bus_i = 8'h3c, bus_o, bus_oe;
  logic [244:0] pins = {5{49'h1_2345_6789_abcd}}, d, q;
  int           bad_count = 0, checks_done = 0;
  // identity values are arbitrary
  bsr_tap #(.MAKER_ID(11'h2a3), .DEVICE_ID(16'h5c3a), .VERSION_ID(4'h9)) bsr_tap_i (.i_mclk(clk), .i_resetn(rst_n),
    .i_test_clock_pin(tck), .i_test_mode_select_pin(tms), .i_test_serial_in_pin(tdi), .i_test_reset_n_pin(trst_n),
    .o_test_serial_out_pin(tdo), .o_test_serial_out_oe(tdo_oe), .i_pin_sample(pins), .i_port0_tx_serial_out(tx_i),
    .i_cpu_bus_out(bus_i), .i_cpu_bus_oe(oe_i), .o_port0_tx_serial_out(tx_o), .o_port0_tx_serial_oe(tx_oe),
    .o_cpu_bus_out(bus_o), .o_cpu_bus_oe(bus_oe), .o_test_mode(mode));
  bsr_tester bsr_tester_i (.i_mclk(clk), .i_tdo(tdo_oe ? tdo : ~tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  task automatic st(input logic ms, input logic di);
    bsr_tester_i.step(ms, di, b);
  endtask : st
  // from idle: one instruction or data scan of n bits, back to idle
  task automatic scan(input bit ir, input int n, input logic [244:0] din);
    st(1'b1, 1'b0);
    if (ir) st(1'b1, 1'b0);
    repeat (2) st(1'b0, 1'b0);
    for (int k = 0; k < n; k++) begin
      st(k == n - 1, din[k]);
      q[k] = b;
    end
    st(1'b1, 1'b0);
    st(1'b0, 1'b0);
  endtask : scan
  task automatic test_id();
    scan(1'b0, 32, '0);
    `CHK(q[31:0], {4'h9, 16'h5c3a, 11'h2a3, 1'b1})
    $display("identification done");
  endtask : test_id
  task automatic test_bypass();
    logic [2:0] codes [3] = '{3'h7, 3'h5, 3'h6};
    foreach (codes[i]) begin
      scan(1'b1, 3, codes[i]);
      `CHK(q[1:0], 2'b01)
      scan(1'b0, 8, 8'hb4);
      `CHK(q[7:0], 8'h68)
    end
    $display("bypass done");
  endtask : test_bypass
  task automatic test_sample();
    d = '0;
    d[161] = 1'b1;
    d[210] = 1'b1;
    for (int k = 0; k < 8; k++) d[196 + 2 * k] = k inside {0, 2, 5, 7};
    scan(1'b1, 3, 3'h2);
    scan(1'b0, 245, d);
    `CHK(q, pins)
    `CHK({mode, tx_o, bus_o}, {1'b0, tx_i, bus_i})
    $display("sample done");
  endtask : test_sample
  task automatic test_extest();
    scan(1'b1, 3, 3'h0);
    `CHK({mode, bus_o, bus_oe}, {1'b1, 8'ha5, 8'hff})
    `CHK({tx_oe, tx_o}, 2'b10)
    @(posedge clk) pins <= ~pins;
    scan(1'b0, 245, d);
    `CHK(q, pins)
    $display("extest done");
  endtask : test_extest
  task automatic test_clamp();
    scan(1'b1, 3, 3'h3);
    scan(1'b0, 8, 8'hff);
    `CHK(q[7:0], 8'hfe)
    `CHK({mode, bus_o, bus_oe, tx_oe}, {1'b1, 8'ha5, 8'hff, 1'b1})
    scan(1'b1, 3, 3'h4);
    `CHK({mode, bus_oe, tx_oe}, {1'b1, 9'h0})
    $display("clamp and float done");
  endtask : test_clamp
  task automatic test_treset();
    @(posedge clk);
    bus_i <= 8'hc3;
    trst_n <= 1'b0;
    repeat (6) @(posedge clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK({mode, bus_o}, {1'b0, 8'hc3})
    st(1'b0, 1'b0);
    test_id();
    $display("test reset done");
  endtask : test_treset
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) st(1'b1, 1'b0);
    st(1'b0, 1'b0);
    test_id();
    test_bypass();
    test_sample();
    test_extest();
    test_clamp();
    test_treset();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : test_bsr_tap
`default_nettype wire
